// *** wor_pkg.sv ***
package wor_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [15:0] OPTION_TWO_ADDR = 16'h001E;
  localparam logic [15:0] OPTION_ONE_ADDR = 16'h001F;
  localparam logic [7:0] OPTION_TWO_RESET = 8'h00;
  localparam logic [6:0] OPTION_ONE_RESET = 7'h00;
  localparam logic [0:0] RANGE_RESET = 1'h0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ************************************************************
  // Field positions, system_option_two
  // ************************************************************
  localparam int TWO_BAUD_SRC_BIT = 0;
  localparam int TWO_OSC_STOP_BIT = 1;
  localparam int TWO_PUMP_LOWV_BIT = 2;

  // ************************************************************
  // Field positions, system_option_one
  // ************************************************************
  localparam int ONE_WDOG_DIS_BIT = 0;
  localparam int ONE_STOP_EN_BIT = 1;
  localparam int ONE_SHORT_REC_BIT = 2;
  localparam int ONE_MON_PWR_DIS_BIT = 3;
  localparam int ONE_MON_RST_DIS_BIT = 4;
  localparam int ONE_MON_STOP_EN_BIT = 5;
  localparam int ONE_WDOG_RATE_BIT = 6;
  localparam int ONE_RANGE_BIT = 7;

  // ************************************************************
  // Timing, in crystal clock cycles
  // ************************************************************
  localparam int TIMEOUT_W = 19;
  localparam logic [18:0] WDOG_SHORT_TIMEOUT = 19'h0_1FF0;
  localparam logic [18:0] WDOG_LONG_TIMEOUT = 19'h3_FFF0;
  localparam int REC_W = 13;
  localparam logic [12:0] SHORT_RECOVERY = 13'h0020;
  localparam logic [12:0] LONG_RECOVERY = 13'h1000;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } wor_bus_req_t;

  typedef struct packed {
    logic pump_regulator_lowv_enable;
    logic osc_run_in_stop;
    logic serial_baud_clock_source;
    logic watchdog_rate_select;
    logic supply_monitor_stop_enable;
    logic supply_monitor_reset_disable;
    logic supply_monitor_power_disable;
    logic supply_monitor_voltage_range;
    logic short_stop_recovery;
    logic stop_enable;
    logic watchdog_disable;
  } wor_options_t;

endpackage : wor_pkg

// *** wor_once_reg.sv ***
`timescale 1ns/1ps
module wor_once_reg #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_wr,
  input wire logic [WIDTH-1:0] i_wdata,
  output logic [WIDTH-1:0] o_q,
  output logic o_done
);

  initial begin
    if (WIDTH < 1) begin
      $error("wor_once_reg: WIDTH must be at least 1");
    end
  end

  wire logic take = i_wr && !o_done;

  // ************************************************************
  // Write-once latch
  // ************************************************************
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_q <= RESET_VAL;
      o_done <= 1'b0;
    end else if (take) begin
      o_q <= i_wdata;
      o_done <= 1'b1;
    end
  end

endmodule : wor_once_reg

// *** wor_recovery_timer.sv ***
`timescale 1ns/1ps
module wor_recovery_timer #(
  parameter int WIDTH = wor_pkg::REC_W
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_start,
  input wire logic [WIDTH-1:0] i_cycles,
  input wire logic i_tick,
  output logic o_busy,
  output logic o_done
);

  initial begin
    if (WIDTH < 2) begin
      $error("wor_recovery_timer: WIDTH must be at least 2");
    end
  end

  logic [WIDTH-1:0] count;
  wire logic last = o_busy && i_tick && (count == WIDTH'(1));

  // ************************************************************
  // Countdown in crystal ticks
  // ************************************************************
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      count <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= last;
      if (i_start) begin
        count <= i_cycles;
        o_busy <= 1'b1;
      end else if (last) begin
        count <= '0;
        o_busy <= 1'b0;
      end else if (o_busy && i_tick) begin
        count <= count - WIDTH'(1);
      end
    end
  end

endmodule : wor_recovery_timer

// *** wor_option_bank.sv ***
`timescale 1ns/1ps
module wor_option_bank (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_por_rstn,
  input wire wor_pkg::wor_bus_req_t i_bus,
  output logic [7:0] o_rdata,
  input wire logic i_stop_mode,
  input wire logic i_stop_exec,
  input wire logic i_wake_event,
  input wire logic i_wake_by_reset,
  input wire logic i_crystal_clock_tick,
  input wire logic i_supply_monitor_reset_req,
  output wor_pkg::wor_options_t o_options,
  output logic o_pump_regulator_on,
  output logic o_osc_enable,
  output logic o_serial_clk_from_bus,
  output logic [18:0] o_watchdog_timeout,
  output logic o_watchdog_enable,
  output logic o_supply_monitor_powered,
  output logic o_supply_monitor_reset,
  output logic o_supply_monitor_5v,
  output logic o_stop_enter,
  output logic o_illegal_opcode,
  output logic o_stop_recovering,
  output logic o_stop_recovery_done,
  output logic o_option_two_locked,
  output logic o_option_one_locked,
  output logic o_range_locked
);

  // ************************************************************
  // Resets
  // ************************************************************
  // Power-on reset is also a system reset
  wire logic any_rstn = i_rstn && i_por_rstn;

  // ************************************************************
  // Address decode
  // ************************************************************
  // decode two addresses
  wire logic sel_two = (i_bus.addr == wor_pkg::OPTION_TWO_ADDR);
  wire logic sel_one = (i_bus.addr == wor_pkg::OPTION_ONE_ADDR);
  wire logic wr_two = i_bus.wr && sel_two;
  wire logic wr_one = i_bus.wr && sel_one;

  // ************************************************************
  // Option latches
  // ************************************************************
  logic [7:0] two_q;
  logic [6:0] one_q;
  logic [0:0] range_q;

  wor_once_reg #(
    .WIDTH(8),
    .RESET_VAL(wor_pkg::OPTION_TWO_RESET)
  ) u_two (
    .i_ref_clk(i_ref_clk),
    .i_rstn(any_rstn),
    .i_wr(wr_two),
    .i_wdata(i_bus.wdata),
    .o_q(two_q),
    .o_done(o_option_two_locked)
  );

  wor_once_reg #(
    .WIDTH(7),
    .RESET_VAL(wor_pkg::OPTION_ONE_RESET)
  ) u_one (
    .i_ref_clk(i_ref_clk),
    .i_rstn(any_rstn),
    .i_wr(wr_one),
    .i_wdata(i_bus.wdata[6:0]),
    .o_q(one_q),
    .o_done(o_option_one_locked)
  );

  // range bit armed by power-on only
  wor_once_reg #(
    .WIDTH(1),
    .RESET_VAL(wor_pkg::RANGE_RESET)
  ) u_range (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_por_rstn),
    .i_wr(wr_one),
    .i_wdata(i_bus.wdata[wor_pkg::ONE_RANGE_BIT]),
    .o_q(range_q),
    .o_done(o_range_locked)
  );

  wire logic [7:0] one_view = {range_q, one_q};

  // ************************************************************
  // Field extraction
  // ************************************************************
  wor_pkg::wor_options_t opt;
  assign opt.pump_regulator_lowv_enable = two_q[wor_pkg::TWO_PUMP_LOWV_BIT];
  assign opt.osc_run_in_stop = two_q[wor_pkg::TWO_OSC_STOP_BIT];
  assign opt.serial_baud_clock_source = two_q[wor_pkg::TWO_BAUD_SRC_BIT];
  assign opt.watchdog_rate_select = one_view[wor_pkg::ONE_WDOG_RATE_BIT];
  assign opt.supply_monitor_stop_enable = one_view[wor_pkg::ONE_MON_STOP_EN_BIT];
  assign opt.supply_monitor_reset_disable = one_view[wor_pkg::ONE_MON_RST_DIS_BIT];
  assign opt.supply_monitor_power_disable = one_view[wor_pkg::ONE_MON_PWR_DIS_BIT];
  assign opt.supply_monitor_voltage_range = one_view[wor_pkg::ONE_RANGE_BIT];
  assign opt.short_stop_recovery = one_view[wor_pkg::ONE_SHORT_REC_BIT];
  assign opt.stop_enable = one_view[wor_pkg::ONE_STOP_EN_BIT];
  assign opt.watchdog_disable = one_view[wor_pkg::ONE_WDOG_DIS_BIT];
  assign o_options = opt;

  // ************************************************************
  // Read path
  // ************************************************************
  // read any time
  wire logic [7:0] next_rdata = !i_bus.rd ? wor_pkg::UNMAPPED_READ :
                                sel_two ? two_q :
                                sel_one ? one_view :
                                wor_pkg::UNMAPPED_READ;

  always_ff @(posedge i_ref_clk) begin
    if (!any_rstn) begin
      o_rdata <= wor_pkg::UNMAPPED_READ;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  // ************************************************************
  // Option effects
  // ************************************************************
  // regulator off when set
  assign o_pump_regulator_on = !opt.pump_regulator_lowv_enable;
  assign o_osc_enable = !i_stop_mode || opt.osc_run_in_stop;
  assign o_serial_clk_from_bus = opt.serial_baud_clock_source;
  assign o_watchdog_timeout = opt.watchdog_rate_select ?
                              wor_pkg::WDOG_SHORT_TIMEOUT : wor_pkg::WDOG_LONG_TIMEOUT;
  assign o_watchdog_enable = !opt.watchdog_disable;
  assign o_supply_monitor_powered = !opt.supply_monitor_power_disable &&
                                    (!i_stop_mode || opt.supply_monitor_stop_enable);
  assign o_supply_monitor_reset = i_supply_monitor_reset_req &&
                                  !opt.supply_monitor_reset_disable;
  assign o_supply_monitor_5v = opt.supply_monitor_voltage_range;
  assign o_stop_enter = i_stop_exec && opt.stop_enable;
  assign o_illegal_opcode = i_stop_exec && !opt.stop_enable;

  // ************************************************************
  // Stop recovery
  // ************************************************************
  // reset wake uses long delay
  wire logic use_short = opt.short_stop_recovery && !i_wake_by_reset;
  wire logic [12:0] rec_cycles = use_short ? wor_pkg::SHORT_RECOVERY :
                                 wor_pkg::LONG_RECOVERY;

  wor_recovery_timer #(
    .WIDTH(wor_pkg::REC_W)
  ) u_recovery (
    .i_ref_clk(i_ref_clk),
    .i_rstn(any_rstn),
    .i_start(i_wake_event),
    .i_cycles(rec_cycles),
    .i_tick(i_crystal_clock_tick),
    .o_busy(o_stop_recovering),
    .o_done(o_stop_recovery_done)
  );

endmodule : wor_option_bank

// *** wor_option_bank_assertions.sv ***
`timescale 1ns/1ps
module wor_option_bank_assertions (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_por_rstn,
  input wire wor_pkg::wor_bus_req_t i_bus,
  input wire logic [7:0] o_rdata,
  input wire logic i_stop_mode,
  input wire logic i_stop_exec,
  input wire logic i_wake_event,
  input wire logic i_supply_monitor_reset_req,
  input wire wor_pkg::wor_options_t o_options,
  input wire logic o_pump_regulator_on,
  input wire logic o_osc_enable,
  input wire logic [18:0] o_watchdog_timeout,
  input wire logic o_supply_monitor_reset,
  input wire logic o_stop_enter,
  input wire logic o_illegal_opcode,
  input wire logic o_stop_recovering,
  input wire logic o_option_two_locked,
  input wire logic o_option_one_locked
);
  // ************************************************************
  // Bus decode and properties
  // ************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn || !i_por_rstn);
  wire rd_one = i_bus.rd && (i_bus.addr == wor_pkg::OPTION_ONE_ADDR);
  wire wr_one = i_bus.wr && (i_bus.addr == wor_pkg::OPTION_ONE_ADDR);
  wire wr_two = i_bus.wr && (i_bus.addr == wor_pkg::OPTION_TWO_ADDR);
  wire [7:0] one_q = {o_options.supply_monitor_voltage_range, o_options.watchdog_rate_select,
    o_options.supply_monitor_stop_enable, o_options.supply_monitor_reset_disable,
    o_options.supply_monitor_power_disable, o_options.short_stop_recovery,
    o_options.stop_enable, o_options.watchdog_disable};
  wire [2:0] two_q = {o_options.pump_regulator_lowv_enable, o_options.osc_run_in_stop,
    o_options.serial_baud_clock_source};

  chk_read_back: assert property (rd_one |=> o_rdata == one_q)
    else $error("read data differs from latched settings");
  chk_rdata_idle: assert property (!i_bus.rd |=> o_rdata == 8'h00)
    else $error("read data not zero outside read");
  chk_lock_hold: assert property (o_option_one_locked && wr_one |=> $stable(o_options))
    else $error("locked register changed on write");
  chk_first_write: assert property (!o_option_two_locked && wr_two |=>
    o_option_two_locked && two_q == $past(i_bus.wdata[2:0]))
    else $error("first write not latched");
  chk_pump_off: assert property (o_pump_regulator_on == !two_q[2])
    else $error("pump regulator control wrong");
  chk_wdog_time: assert property (o_watchdog_timeout ==
    (o_options.watchdog_rate_select ? 19'h0_1FF0 : 19'h3_FFF0))
    else $error("watchdog timeout wrong");
  chk_mon_reset: assert property (o_supply_monitor_reset ==
    (i_supply_monitor_reset_req && !o_options.supply_monitor_reset_disable))
    else $error("monitor reset gating wrong");
  chk_stop_decode: assert property (i_stop_exec |->
    o_stop_enter == o_options.stop_enable && o_illegal_opcode == !o_options.stop_enable)
    else $error("stop decode wrong");
  chk_osc_stop: assert property (o_osc_enable == (!i_stop_mode || two_q[1]))
    else $error("oscillator enable wrong");
  chk_wake_busy: assert property (i_wake_event |=> o_stop_recovering)
    else $error("recovery did not start");

  cov_locked_write: cover property (o_option_one_locked && wr_one);
  cov_illegal_stop: cover property (i_stop_exec && o_illegal_opcode);
  cov_wake: cover property (i_wake_event);
endmodule : wor_option_bank_assertions

bind wor_option_bank wor_option_bank_assertions u_chk (.i_ref_clk, .i_rstn, .i_por_rstn,
  .i_bus, .o_rdata, .i_stop_mode, .i_stop_exec, .i_wake_event, .i_supply_monitor_reset_req,
  .o_options, .o_pump_regulator_on, .o_osc_enable, .o_watchdog_timeout,
  .o_supply_monitor_reset, .o_stop_enter, .o_illegal_opcode, .o_stop_recovering,
  .o_option_two_locked, .o_option_one_locked);

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
  logic i_ref_clk, i_rstn, i_por_rstn, i_stop_mode, i_stop_exec, i_wake_event;
  logic i_wake_by_reset, i_crystal_clock_tick, i_supply_monitor_reset_req;
  wor_pkg::wor_bus_req_t i_bus;
  logic [7:0] o_rdata;
  logic [18:0] o_watchdog_timeout;
  logic o_pump_regulator_on, o_osc_enable, o_serial_clk_from_bus, o_watchdog_enable;
  logic o_supply_monitor_powered, o_supply_monitor_reset, o_supply_monitor_5v, o_stop_enter;
  logic o_illegal_opcode, o_stop_recovering, o_stop_recovery_done, o_option_one_locked;
  logic o_range_locked, o_option_two_locked;
  wor_pkg::wor_options_t o_options;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;

  wor_option_bank u_wor_option_bank (.i_ref_clk, .i_rstn, .i_por_rstn, .i_bus, .o_rdata,
    .i_stop_mode, .i_stop_exec, .i_wake_event, .i_wake_by_reset, .i_crystal_clock_tick,
    .i_supply_monitor_reset_req, .o_options, .o_pump_regulator_on, .o_osc_enable,
    .o_serial_clk_from_bus, .o_watchdog_timeout, .o_watchdog_enable, .o_supply_monitor_powered,
    .o_supply_monitor_reset, .o_supply_monitor_5v, .o_stop_enter, .o_illegal_opcode,
    .o_stop_recovering, .o_stop_recovery_done, .o_option_two_locked, .o_option_one_locked,
    .o_range_locked);

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      n_mismatch++;
      conclude();
    end
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic conclude;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [18:0] got, input logic [18:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic [15:0] a, input logic [7:0] d, input logic w);
    @(posedge i_ref_clk);
    i_bus <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge i_ref_clk);
    i_bus <= '0;
  endtask : bus

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    bus(a, 8'h00, 1'b0);
    #1 chk(o_rdata, e);
  endtask : rd

  task automatic rst(input logic por, input int n);
    @(posedge i_ref_clk);
    i_rstn <= 1'b0;
    i_por_rstn <= !por;
    repeat (n) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    i_por_rstn <= 1'b1;
  endtask : rst

  task automatic drive(input logic sm, input logic se, input logic rq);
    @(posedge i_ref_clk);
    i_stop_mode <= sm;
    i_stop_exec <= se;
    i_supply_monitor_reset_req <= rq;
    #1;
  endtask : drive

  task automatic recov(input logic by_rst, input int n);
    int k;
    @(posedge i_ref_clk);
    i_wake_event <= 1'b1;
    i_wake_by_reset <= by_rst;
    @(posedge i_ref_clk);
    i_wake_event <= 1'b0;
    i_crystal_clock_tick <= 1'b1;
    repeat (n - 1) @(posedge i_ref_clk);
    #1 chk(o_stop_recovering, 1'b1);
    @(posedge i_ref_clk);
    i_crystal_clock_tick <= 1'b0;
    #1 chk(o_stop_recovering, 1'b0);
    k = 0;
    while (o_stop_recovery_done !== 1'b1 && k < 2) begin
      @(posedge i_ref_clk);
      #1 k++;
    end
    chk(o_stop_recovery_done, 1'b1);
  endtask : recov

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_defaults;
    rd(16'h001E, 8'h00);
    rd(16'h001F, 8'h00);
    chk(o_watchdog_timeout, 19'h3_FFF0);
    chk({o_pump_regulator_on, o_watchdog_enable}, 2'h3);
    chk(o_options, 11'h000);
    chk({o_option_two_locked, o_option_one_locked, o_range_locked}, 3'h0);
  endtask : t_defaults

  task automatic t_once;
    bus(16'h001F, 8'hA5, 1'b1);
    #1 chk({o_option_two_locked, o_option_one_locked}, 2'h1);
    bus(16'h001E, 8'h07, 1'b1);
    rd(16'h001F, 8'hA5);
    rd(16'h001E, 8'h07);
    bus(16'h001F, 8'h5A, 1'b1);
    bus(16'h001E, 8'h00, 1'b1);
    bus(16'h0020, 8'hFF, 1'b1);
    rd(16'h001F, 8'hA5);
    rd(16'h001E, 8'h07);
    rd(16'h0020, 8'h00);
    chk(o_options, 11'h74D);
    chk({o_option_two_locked, o_option_one_locked, o_range_locked}, 3'h7);
    chk({o_pump_regulator_on, o_serial_clk_from_bus}, 2'h1);
    chk({o_watchdog_enable, o_supply_monitor_5v}, 2'h1);
    drive(1'b1, 1'b1, 1'b1);
    chk({o_osc_enable, o_supply_monitor_powered}, 2'h3);
    chk({o_supply_monitor_reset, o_illegal_opcode, o_stop_enter}, 3'h6);
    drive(1'b0, 1'b0, 1'b0);
  endtask : t_once

  task automatic t_plain;
    rst(1'b0, 2);
    #1 chk({o_option_one_locked, o_range_locked}, 2'h1);
    rd(16'h001F, 8'h80);
    bus(16'h001F, 8'h52, 1'b1);
    rd(16'h001F, 8'hD2);
    chk(o_watchdog_timeout, 19'h0_1FF0);
    drive(1'b1, 1'b1, 1'b1);
    chk({o_osc_enable, o_supply_monitor_powered}, 2'h0);
    chk({o_supply_monitor_reset, o_illegal_opcode, o_stop_enter}, 3'h1);
    drive(1'b0, 1'b0, 1'b0);
  endtask : t_plain

  task automatic t_por;
    rst(1'b1, 2);
    #1 chk({o_option_one_locked, o_range_locked}, 2'h0);
    bus(16'h001F, 8'h0C, 1'b1);
    rd(16'h001F, 8'h0C);
    chk(o_supply_monitor_powered, 1'b0);
    recov(1'b0, 32);
    recov(1'b1, 4096);
  endtask : t_por

  initial begin
    i_rstn = 1'b0;
    i_por_rstn = 1'b0;
    i_bus = '0;
    {i_stop_mode, i_stop_exec, i_wake_event, i_wake_by_reset} = 4'h0;
    {i_crystal_clock_tick, i_supply_monitor_reset_req} = 2'h0;
    rst(1'b1, 20);
    t_defaults();
    t_once();
    t_plain();
    t_por();
    conclude();
  end
endmodule : tb
